// ===== logic/ampw_write_port.sv
// Purpose: Write sequencer for a muxed address/data external memory port
// Assumes: Avalon-MM register slave; all pin timing in peripheral clocks
// Notes:   One 32-bit word is sent per go command
`timescale 1ns/10ps
`include "ampw_defines.svh"
module ampw_write_port import ampw_pkg::*; (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // External memory pins
  output logic             addrLatch,
  output logic             writeStrobeN,
  output logic      [15:0] muxedAddrDataBusOut,
  output logic             muxedAddrDataBusOe
);

  ampw_tim_if tim ();

  ampw_core_t q;    // Current state
  ampw_core_t nx;   // Next state
  logic       busy; // Word pending or in flight

  // Reset image of the state
  localparam ampw_core_t CoreRst = '{st: ST_IDLE, wrN: 1'b1, waitReq: 1'b1,
                                      ctrl: `AMPW_CTRL_RST, default: '0};

  // Peripheral clock enable
  ampw_pclk_div uDiv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tim     (tim)
  );

  // Strobe lengths from settings
  ampw_strobe_calc uCalc (
    .tim (tim)
  );

  // Settings to the length calculator
  assign tim.dur  = q.ctrl[`AMPW_CTRL_DUR_HI:`AMPW_CTRL_DUR_LO];
  assign tim.hold = q.ctrl[`AMPW_CTRL_HOLD];
  assign tim.slow = q.ctrl[`AMPW_CTRL_SLOW];

  // Merge write data under byte enables
  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus value for an address phase or a data beat
  function automatic logic [15:0] busLane(input logic [9:0] c, input logic [23:0] a,
                                          input logic [31:0] d, input logic [1:0] b,
                                          input logic addrPh);
    logic [15:0] v;
    if (addrPh) begin
      // 16-bit packed mode latches a new address per halfword
      v = c[`AMPW_CTRL_W16] ? a[15:0] + {14'h0000, b} : a[15:0];
    end else if (c[`AMPW_CTRL_W16]) begin
      v = b[0] ? d[31:16] : d[15:0];
    end else begin
      v = {a[23:16], 8'(d >> {b, 3'h0})};
    end
    return v;
  endfunction

  // Last strobe of the current latch phase
  function automatic logic grpLast(input logic [9:0] c, input logic [1:0] b);
    if (c[`AMPW_CTRL_W16]) begin
      return c[`AMPW_CTRL_PACK] || (b == `AMPW_LAST16);
    end
    return b == `AMPW_LAST8;
  endfunction

  // Pin level of the latch strobe
  function automatic logic aleLevel(input logic [9:0] c, input logic on);
    return on ^ c[`AMPW_CTRL_ALELOW];
  endfunction

  // Close a latch group: next address phase or back to idle
  function automatic ampw_core_t endGroup(input ampw_core_t s);
    ampw_core_t r;
    r = s;
    if (s.beat == (s.ctrl[`AMPW_CTRL_W16] ? `AMPW_LAST16 : `AMPW_LAST8)) begin
      // Word done, release the bus
      r.st = ST_IDLE;
      r.adOe = 1'b0;
    end else begin
      // New address phase for the next beat
      r.beat = s.beat + 2'h1;
      r.st = ST_ALE;
      r.cnt = `AMPW_ALE_TICKS - 5'h01;
      r.ale = aleLevel(s.ctrl, 1'b1);
      r.ad = busLane(s.ctrl, s.addr, s.data, r.beat, 1'b1);
    end
    return r;
  endfunction

  assign busy = q.go || (q.st != ST_IDLE);

  // Register access and sequencer
  always_comb begin
    nx = q;
    nx.waitReq = 1'b1;
    // Take a request once; writes wait while a word is in flight
    if ((avs_read || avs_write) && q.waitReq && !(avs_write && busy)) begin
      nx.waitReq = 1'b0;
      if (avs_write) begin
        case (avs_address)
          `AMPW_OFS_CTRL: begin
            nx.ctrl = 10'(beMerge({22'h000000, q.ctrl}, avs_writedata, avs_byteenable));
          end
          `AMPW_OFS_ADDR: begin
            nx.addr = 24'(beMerge({8'h00, q.addr}, avs_writedata, avs_byteenable));
          end
          `AMPW_OFS_DATA: begin
            nx.data = beMerge(q.data, avs_writedata, avs_byteenable);
          end
          `AMPW_OFS_CMD: begin
            nx.go = avs_byteenable[0] && avs_writedata[`AMPW_CMD_GO];
          end
          default: begin
            // Read-only or unmapped: accepted and dropped
          end
        endcase
      end else begin
        case (avs_address)
          `AMPW_OFS_CTRL: nx.rdData = {22'h000000, q.ctrl};
          `AMPW_OFS_ADDR: nx.rdData = {8'h00, q.addr};
          `AMPW_OFS_DATA: nx.rdData = q.data;
          `AMPW_OFS_STAT: nx.rdData = {26'h0000000, q.st, q.beat, busy};
          default:        nx.rdData = 32'h00000000;
        endcase
      end
    end
    // Sequencer steps once per peripheral clock
    if (tim.tick) begin
      case (q.st)
        ST_IDLE: begin
          if (q.go) begin
            // Address phase for beat zero
            nx.go = 1'b0;
            nx.beat = 2'h0;
            nx.st = ST_ALE;
            nx.cnt = `AMPW_ALE_TICKS - 5'h01;
            nx.ale = aleLevel(q.ctrl, 1'b1);
            nx.ad = busLane(q.ctrl, q.addr, q.data, 2'h0, 1'b1);
            nx.adOe = 1'b1;
          end
        end
        ST_ALE: begin
          if (q.cnt == 5'h00) begin
            // Latch strobe drops; address still held a clock
            nx.st = ST_SETUP;
            nx.cnt = `AMPW_SETUP_TICKS - 5'h01;
            nx.ale = aleLevel(q.ctrl, 1'b0);
          end else begin
            nx.cnt = q.cnt - 5'h01;
          end
        end
        ST_SETUP: begin
          if (q.cnt == 5'h00) begin
            // Strobe falls two clocks after the latch
            nx.st = ST_STROBE;
            nx.cnt = tim.strbLen - 5'h01;
            nx.wrN = 1'b0;
          end else begin
            // Data one clock ahead of the strobe
            nx.cnt = q.cnt - 5'h01;
            nx.ad = busLane(q.ctrl, q.addr, q.data, q.beat, 1'b0);
          end
        end
        ST_STROBE: begin
          if (q.cnt != 5'h00) begin
            nx.cnt = q.cnt - 5'h01;
          end else begin
            // Strobe rises; memory takes data on this edge
            nx.wrN = 1'b1;
            if (!grpLast(q.ctrl, q.beat)) begin
              nx.st = ST_RECOV;
              nx.cnt = tim.gapLen - 5'h01;
            end else if (tim.lastLen != 5'h00) begin
              nx.st = ST_RECOV;
              nx.cnt = tim.lastLen - 5'h01;
            end else begin
              nx = endGroup(nx);
            end
          end
        end
        ST_RECOV: begin
          if (q.cnt != 5'h00) begin
            // Bus held through hold and recovery
            nx.cnt = q.cnt - 5'h01;
          end else if (grpLast(q.ctrl, q.beat)) begin
            nx = endGroup(q);
          end else begin
            // Next strobe in the same latch phase
            nx.beat = q.beat + 2'h1;
            nx.st = ST_STROBE;
            nx.cnt = tim.strbLen - 5'h01;
            nx.wrN = 1'b0;
            nx.ad = busLane(q.ctrl, q.addr, q.data, nx.beat, 1'b0);
          end
        end
        default: begin
          nx = CoreRst;
        end
      endcase
    end
    // Idle latch level follows the programmed polarity
    if (nx.st == ST_IDLE) begin
      nx.ale = aleLevel(nx.ctrl, 1'b0);
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= CoreRst;
    end else begin
      q <= nx;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata        = q.rdData;
  assign avs_waitrequest     = q.waitReq;
  assign addrLatch           = q.ale;
  assign writeStrobeN        = q.wrN;
  assign muxedAddrDataBusOut = q.ad;
  assign muxedAddrDataBusOe  = q.adOe;

  // Checking helpers
  logic       aleAct;   // Latch strobe asserted
  logic       w16;      // 16-bit width selected
  logic [7:0] lowCnt;   // Clocks strobe has been low
  logic [7:0] hiCnt;    // Clocks strobe has been high
  logic [2:0] strbSeen; // Strobes since the last address phase

  assign aleAct = q.ale ^ q.ctrl[`AMPW_CTRL_ALELOW];
  assign w16 = q.ctrl[`AMPW_CTRL_W16];

  // Strobe length and count tracking
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= 8'h00;
      hiCnt <= 8'h00;
      strbSeen <= 3'h0;
    end else begin
      lowCnt <= q.wrN ? 8'h00 : lowCnt + 8'h01;
      hiCnt <= q.wrN ? hiCnt + 8'h01 : 8'h00;
      // Cleared while idle too, so a new word never sees the last word's tally
      if (q.st == ST_ALE || q.st == ST_IDLE) begin
        strbSeen <= 3'h0;
      end else if (q.wrN && !nx.wrN) begin
        strbSeen <= strbSeen + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Latch held two peripheral clocks
  sequence aleHeld;
    aleAct [*4] ##1 !aleAct;
  endsequence

  // Strobe falls two peripheral clocks after the latch
  sequence setupGap;
    writeStrobeN [*4] ##1 !writeStrobeN;
  endsequence

  ale_pulse_a: assert property ($rose(aleAct) |-> aleHeld)
    else $error("latch pulse not two peripheral clocks");
  strobe_delay_a: assert property ($fell(aleAct) |-> setupGap)
    else $error("strobe not two peripheral clocks after latch");
  strobe_len_a: assert property ($rose(q.wrN) |-> lowCnt == {2'h0, tim.strbLen, 1'b0})
    else $error("strobe low time wrong");
  strobe_gap_a: assert property ($fell(q.wrN) && strbSeen > 3'h1
    |-> hiCnt == {2'h0, tim.gapLen, 1'b0})
    else $error("gap between strobes wrong");
  burst_four_a: assert property (($rose(aleAct) || $rose(q.st == ST_IDLE))
    && strbSeen != 3'h0 && !w16 |-> strbSeen == 3'h4)
    else $error("8-bit group not four strobes");
  pack_one_a: assert property (($rose(aleAct) || $rose(q.st == ST_IDLE))
    && strbSeen != 3'h0 && w16 && q.ctrl[`AMPW_CTRL_PACK] |-> strbSeen == 3'h1)
    else $error("packed 16-bit group not one strobe");
  pack_multi_a: assert property (($rose(aleAct) || $rose(q.st == ST_IDLE))
    && strbSeen != 3'h0 && w16 && !q.ctrl[`AMPW_CTRL_PACK] |-> strbSeen == 3'h2)
    else $error("unpacked 16-bit group not two strobes");
  hold_bus_a: assert property ($rose(q.wrN) && q.ctrl[`AMPW_CTRL_HOLD]
    |-> ($stable(q.ad) && q.adOe) [*2])
    else $error("bus not held after strobe");
  strobe_data_a: assert property (!q.wrN && !$past(q.wrN) |-> $stable(q.ad) && q.adOe)
    else $error("data moved during strobe");
  upper_addr_a: assert property (!q.wrN && !w16 |-> q.ad[15:8] == q.addr[23:16])
    else $error("upper address missing in 8-bit strobe");
  ale_idle_a: assert property (q.st == ST_IDLE |-> ##1 (q.st != ST_IDLE || !aleAct))
    else $error("latch active while idle");
  pclk_edge_a: assert property ($changed(q.wrN) || $changed(aleAct) |-> $past(tim.tick))
    else $error("pin moved off a peripheral clock");

endmodule

// ===== logic/ampw_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM register window, byte addressed
// Notes:   Shared by every design module and the bench
`ifndef AMPW_DEFINES_SVH
`define AMPW_DEFINES_SVH

// Register byte offsets
`define AMPW_OFS_CTRL 5'h00
`define AMPW_OFS_ADDR 5'h04
`define AMPW_OFS_DATA 5'h08
`define AMPW_OFS_CMD  5'h0c
`define AMPW_OFS_STAT 5'h10

// Control register fields
`define AMPW_CTRL_W16    0
`define AMPW_CTRL_DUR_LO 1
`define AMPW_CTRL_DUR_HI 5
`define AMPW_CTRL_PACK   6
`define AMPW_CTRL_HOLD   7
`define AMPW_CTRL_SLOW   8
`define AMPW_CTRL_ALELOW 9
`define AMPW_CTRL_RST    10'h006

// Command register go bit
`define AMPW_CMD_GO 0

// Core clock and peripheral clock periods, in ns
`define AMPW_CLK_NS  50
`define AMPW_PCLK_NS 100
`define AMPW_PCLK_DIV (`AMPW_PCLK_NS / `AMPW_CLK_NS)

// Phase lengths in peripheral clocks
`define AMPW_ALE_TICKS   5'h02
`define AMPW_SETUP_TICKS 5'h02
`define AMPW_SLOW_TICKS  5'h07
`define AMPW_SLOW_MINDUR 5'h09

// Last beat index of a 32-bit word
`define AMPW_LAST8  2'h3
`define AMPW_LAST16 2'h1

`endif

// ===== logic/ampw_pkg.sv
// Purpose: Types shared by the write port modules
// Assumes: Constants come from ampw_defines.svh
// Notes:   State codes follow a Gray path IDLE-ALE-SETUP-STROBE-RECOV
package ampw_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ALE    = 3'h1,
    ST_SETUP  = 3'h3,
    ST_STROBE = 3'h2,
    ST_RECOV  = 3'h6
  } ampw_state_t;

  // Core state
  typedef struct packed {
    ampw_state_t st;
    logic [4:0]  cnt;
    logic [1:0]  beat;
    logic        go;
    logic        ale;
    logic        wrN;
    logic [15:0] ad;
    logic        adOe;
    logic        waitReq;
    logic [31:0] rdData;
    logic [9:0]  ctrl;
    logic [23:0] addr;
    logic [31:0] data;
  } ampw_core_t;

  // Divider state
  typedef struct packed {
    logic phase;
    logic tick;
  } ampw_div_t;

endpackage

// ===== logic/ampw_tim_if.sv
// Purpose: Carries the peripheral tick and strobe lengths between modules
// Assumes: Single clock domain
// Notes:   Lengths are in peripheral clocks
`timescale 1ns/10ps
interface ampw_tim_if;
  logic       tick;    // One-cycle peripheral clock enable
  logic [4:0] dur;     // Programmed data cycle length
  logic       hold;    // Hold cycle enabled
  logic       slow;    // Slow device mode
  logic [4:0] strbLen; // Write strobe low time
  logic [4:0] gapLen;  // High time between strobes of a group
  logic [4:0] lastLen; // High time after the last strobe of a group
  modport div  (output tick);
  modport calc (input dur, hold, slow, output strbLen, gapLen, lastLen);
  modport core (input tick, strbLen, gapLen, lastLen, output dur, hold, slow);
endinterface

// ===== logic/ampw_pclk_div.sv
// Purpose: Peripheral clock enable at half the core clock rate
// Assumes: clk_sys at 20 MHz
// Notes:   Tick is a registered one-cycle pulse
`timescale 1ns/10ps
`include "ampw_defines.svh"
module ampw_pclk_div import ampw_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Tick out
  ampw_tim_if.div  tim
);

  ampw_div_t q;  // Current state
  ampw_div_t nx; // Next state

  // Tick once every peripheral period
  always_comb begin
    nx = q;
    nx.tick = (q.phase == 1'(`AMPW_PCLK_DIV - 1));
    nx.phase = nx.tick ? 1'b0 : q.phase + 1'b1;
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= nx;
    end
  end

  assign tim.tick = q.tick;

endmodule

// ===== logic/ampw_strobe_calc.sv
// Purpose: Strobe low and high lengths from the control settings
// Assumes: Settings change only while the port is idle
// Notes:   A zero or too short duration yields a one-clock strobe
`timescale 1ns/10ps
`include "ampw_defines.svh"
module ampw_strobe_calc import ampw_pkg::*; (
  // Settings in, lengths out
  ampw_tim_if.calc tim
);

  logic [4:0] slowTicks; // Clocks moved from strobe to recovery
  logic [4:0] durEff;    // Duration with zero read as one

  // Lengths in peripheral clocks
  always_comb begin
    slowTicks = tim.slow ? `AMPW_SLOW_TICKS : 5'h00;
    durEff = (tim.dur == 5'h00) ? 5'h01 : tim.dur;
    tim.strbLen = (durEff > slowTicks) ? durEff - slowTicks : 5'h01;
    tim.gapLen = 5'h01 + {4'h0, tim.hold} + slowTicks;
    tim.lastLen = {4'h0, tim.hold};
  end

endmodule

// ===== verification/ampw_mem_model.sv
// Purpose: Behavioural asynchronous memory watching the muxed write port
// Assumes: Write only; pins sampled on clk_sys rising edges
// Notes:   All widths are counted in core clocks
`timescale 1ns/10ps
module ampw_mem_model (
  // Clock and bench control
  input wire logic        clk_sys,
  input wire logic        clr,
  input wire logic        aleLow,
  // Memory pins
  input wire logic        addrLatch,
  input wire logic        writeStrobeN,
  input wire logic [15:0] busIn,
  input wire logic        busOe
);
  logic [15:0] wAddr [8];  // Address of each write
  logic [15:0] wData [8];  // Data of each write
  int          lowW  [8];  // Strobe low width
  int          gapW  [8];  // High time before each strobe
  int          n     = 0;  // Writes seen
  int          nAle  = 0;  // Latch pulses seen
  int          aleW  = 0;  // Width of last latch pulse
  int          hRun  = 0;  // Bus held after last rise
  int          cAle  = 0;  // Running latch width
  int          cLow  = 0;  // Running strobe low time
  int          cHigh = 0;  // Running strobe high time
  logic [15:0] aAd, latAddr, dLow;  // Bus samples
  logic        pAle  = 1'b0;        // Latch active last cycle
  logic        pWr   = 1'b1;        // Strobe level last cycle
  wire         aleOn = addrLatch ^ aleLow;
  // A released bus reads unknown, never its last value
  wire  [15:0] bus   = busOe ? busIn : 16'hxxxx;

  // Follow latch and strobe edges
  always @(posedge clk_sys) begin
    pAle <= aleOn;
    pWr <= writeStrobeN;
    if (aleOn) begin
      cAle <= cAle + 1;
      aAd <= bus;
    end else if (pAle) begin
      // Address taken as the latch ends
      latAddr <= aAd;
      aleW <= cAle;
      cAle <= 0;
      nAle <= nAle + 1;
    end
    if (writeStrobeN && !pWr) begin
      // Data taken as the strobe rises
      wAddr[n] <= latAddr;
      wData[n] <= dLow;
      lowW[n] <= cLow;
      n <= n + 1;
    end
    if (!writeStrobeN) begin
      cLow <= cLow + 1;
      dLow <= bus;
      if (pWr) begin
        gapW[n] <= cHigh;
      end
    end else begin
      cLow <= 0;
    end
    if ((!aleOn && pAle) || (writeStrobeN && !pWr)) begin
      cHigh <= 1;
    end else if (writeStrobeN) begin
      cHigh <= cHigh + 1;
    end
    // Bus unchanged after a strobe rise
    if (!writeStrobeN) begin
      hRun <= 0;
    end else if (busOe && bus === dLow && (hRun > 0 || !pWr)) begin
      hRun <= hRun + 1;
    end
    // Bench clears the tallies between cases
    if (clr) begin
      n <= 0;
      nAle <= 0;
      cAle <= 0;
      hRun <= 0;
    end
  end
endmodule

// ===== verification/async_mux_memory_write_port_test.sv
// Purpose: Self-checking bench for the muxed write port
// Assumes: 20 MHz clk_sys; Avalon-MM master honouring waitrequest
// Notes:   One peripheral clock is two core clocks in every width check
`timescale 1ns/10ps
`include "ampw_defines.svh"
module async_mux_memory_write_port_test;
  logic        clk_sys, rst_n;              // Clock and reset
  logic [4:0]  avs_address;                 // Register bus
  logic        avs_read, avs_write;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rdData;
  logic        avs_waitrequest;
  logic        addrLatch, writeStrobeN, busOe; // Memory pins
  logic [15:0] busOut;
  logic        clr, aleLow;                 // Model control
  int          err_count, n_compared;       // Tallies

  ampw_write_port ampw_write_port_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN), .muxedAddrDataBusOut(busOut),
    .muxedAddrDataBusOe(busOe));
  ampw_mem_model ampw_mem_model_i (
    .clk_sys(clk_sys), .clr(clr), .aleLow(aleLow), .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN), .busIn(busOut), .busOe(busOe));

  // Core clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic avAccess(input logic rd, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_read <= rd;
    avs_write <= ~rd;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 2000);
    if (k >= 2000) begin
      err_count++;
      $display("FAIL at %0t: no answer at offset %h", $time, a);
    end
    rdData = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Send one word with the given control value and check the pins
  task automatic runCase(input logic [9:0] ctl, input logic [23:0] a, input logic [31:0] d);
    int          nb, s, dd, gap;
    logic [15:0] eD, eA;
    logic        pk;
    pk = ctl[0] & ctl[6];
    aleLow <= ctl[9];
    avAccess(1'b0, `AMPW_OFS_CTRL, {22'h0, ctl});
    clr <= 1'b1;
    avAccess(1'b0, `AMPW_OFS_ADDR, {8'h00, a});
    clr <= 1'b0;
    avAccess(1'b0, `AMPW_OFS_DATA, d);
    chk({31'h0, addrLatch}, {31'h0, ctl[9]}, "latch idle level");
    avAccess(1'b0, `AMPW_OFS_CMD, 32'h1);
    // Reads are never held off, so status shows the word in flight
    avAccess(1'b1, `AMPW_OFS_STAT, 32'h0);
    chk({31'h0, rdData[0]}, 32'h1, "busy after go");
    // Held off while busy, so it returns once the word is out
    avAccess(1'b0, `AMPW_OFS_DATA, ~d);
    // The stalled write must land once the port is idle again
    avAccess(1'b1, `AMPW_OFS_DATA, 32'h0);
    chk(rdData, ~d, "data after stall");
    avAccess(1'b1, `AMPW_OFS_STAT, 32'h0);
    chk(rdData & 32'h39, 32'h0, "idle after word");
    dd = (ctl[5:1] == 5'h00) ? 1 : int'(ctl[5:1]);
    s = ctl[8] ? ((dd > 8) ? dd - 7 : 1) : dd;
    gap = 2 * (1 + (ctl[7] ? 1 : 0) + (ctl[8] ? 7 : 0));
    nb = ctl[0] ? 2 : 4;
    chk(ampw_mem_model_i.n, nb, "strobe count");
    chk(ampw_mem_model_i.nAle, pk ? 2 : 1, "latch count");
    chk(ampw_mem_model_i.aleW, 4, "latch width");
    chk(ampw_mem_model_i.hRun, ctl[7] ? 2 : 0, "hold after last");
    for (int i = 0; i < nb; i++) begin
      eD = ctl[0] ? d[16*i+:16] : {a[23:16], d[8*i+:8]};
      eA = pk ? a[15:0] + 16'(i) : a[15:0];
      chk({16'h0, ampw_mem_model_i.wData[i]}, {16'h0, eD}, "data");
      chk({16'h0, ampw_mem_model_i.wAddr[i]}, {16'h0, eA}, "address");
      chk(ampw_mem_model_i.lowW[i], 2 * s, "strobe width");
      chk(ampw_mem_model_i.gapW[i], (i == 0 || pk) ? 4 : gap, "gap");
    end
  endtask

  // Print the verdict and stop
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done;
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    clr = 1'b0;
    aleLow = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({29'h0, addrLatch, writeStrobeN, busOe}, 32'h2, "idle pins");
    avAccess(1'b1, `AMPW_OFS_CTRL, 32'h0);
    chk(rdData, {22'h0, `AMPW_CTRL_RST}, "control reset");
    avAccess(1'b1, 5'h14, 32'h0);
    chk(rdData, 32'h0, "unmapped read");
    runCase(10'h006, 24'h5a1234, 32'hc3a51e87);
    runCase(10'h08a, 24'h01ff00, 32'h12345678);
    runCase(10'h312, 24'hee0f0f, 32'h9abcdef0);
    runCase(10'h005, 24'h00abcd, 32'h0f1e2d3c);
    runCase(10'h0c9, 24'h00fffe, 32'hdeadbeef);
    runCase(10'h195, 24'h002468, 32'h55aa33cc);
    runCase(10'h000, 24'h7f8001, 32'h80402010);
    runCase(10'h27f, 24'h001357, 32'hfedc0123);
    test_done;
  end
endmodule
